// ===== design/sltfi_pkg.sv
// Purpose: shared constants and types for the serial link transmit frame input
// Assumes: one core clock, synchronous active-low reset
// Notes: frame layout is data bits first, then four coding bits
`default_nettype none
package sltfi_pkg;

  // ****************************************************************
  // word and frame geometry
  // ****************************************************************
  localparam int WIDE_BITS = 20;
  localparam int NARROW_BITS = 16;
  localparam int CODING_BITS = 4;
  localparam int FRAME_MAX = WIDE_BITS + CODING_BITS;
  localparam logic [4:0] LAST_BIT_WIDE = 5'h17;
  localparam logic [4:0] LAST_BIT_NARROW = 5'h13;
  localparam int FIFO_DEPTH = 16;
  localparam int RATE_SEL_W = 2;

  // ****************************************************************
  // coding bit positions inside the four-bit trailer
  // ****************************************************************
  localparam int CODE_FLAG_POS = 0;
  localparam int CODE_CTRL_POS = 1;
  localparam int CODE_FILL_POS = 2;
  localparam int CODE_DATA_POS = 3;

  // ****************************************************************
  // fill patterns; the one type is inverted to steer line balance
  // ****************************************************************
  localparam logic [19:0] FILL_ZERO_WORD = 20'h00000;
  localparam logic [19:0] FILL_ONE_WORD = 20'h0007F;

  // ****************************************************************
  // reset values
  // ****************************************************************
  localparam logic RST_LINE = 1'b0;
  localparam logic RST_FLAG_TOGGLE = 1'b0;
  localparam logic RST_DISP_POS = 1'b0;
  localparam logic RST_READY = 1'b0;
  localparam logic RST_STROBE = 1'b1;

  typedef enum logic {SER_IDLE, SER_SHIFT} sltfi_ser_e;

  typedef struct packed {
    logic wide;
    logic ctrl;
    logic flag;
    logic [19:0] data;
  } sltfi_word_s;

endpackage
`default_nettype wire

// ===== design/sltfi_fifo.sv
// Purpose: word FIFO between the parallel input and the serialiser
// Assumes: DEPTH is a power of two
// Notes: valid/ready on both sides; push and pop may share a cycle
`timescale 1ns/10ps
`default_nettype none
module sltfi_fifo #(
  parameter int WIDTH = 23,
  parameter int DEPTH = 16
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_ptr;
  logic [AW:0] rd_ptr;
  logic push;
  logic pop;

  assign in_ready = (wr_ptr[AW-1:0] != rd_ptr[AW-1:0]) || (wr_ptr[AW] == rd_ptr[AW]);
  assign out_valid = (wr_ptr != rd_ptr);
  assign out_data = mem[rd_ptr[AW-1:0]];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wr_ptr <= '0;
    end else if (push) begin
      wr_ptr <= wr_ptr + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rd_ptr <= '0;
    end else if (pop) begin
      rd_ptr <= rd_ptr + 1'b1;
    end
  end
endmodule // sltfi_fifo
`default_nettype wire

// ===== design/sltfi_top.sv
// Purpose: transmit-side parallel frame input and serialisation control
// Assumes: all inputs synchronous to CORE_CLK; open pads pulled high at the pad ring
// Notes: one frame is loaded per word strobe rising edge that finds the serialiser idle; a FIFO buffers accepted words
//
// Behaviour
// - open request inputs read high, meaning idle
// - control request sends word as control frame
// - control request asks control word in a later frame
// - both requests together give control frame
// - data request means valid payload in a later frame
// - data request sends data plus flag bit
// - wide select sends 20 bits, else 16
// - serialise least significant bit first
// - four coding bits follow, C0 first
// - two-bit select divides bit rate 1/2/4/8
// - loopback select steers stream to loopback output
// - ready output follows permit from receiver while the buffer has room
// - empty buffer or no permit sends fill
// - flag alternates each frame when mode off
// - bit 0 leaves one cycle after strobe
`timescale 1ns/10ps
`default_nettype none
module sltfi_top #(
  parameter int DEPTH = sltfi_pkg::FIFO_DEPTH
) (
  input wire logic CORE_CLK,
  input wire logic RESETN,
  input wire logic [19:0] PARALLEL_WORD_IN,
  input wire logic EXTRA_FLAG_IN,
  input wire logic CONTROL_WORD_REQUEST_N,
  input wire logic PAYLOAD_REQUEST_N,
  input wire logic WIDE_WORD_SELECT,
  input wire logic LINK_PAYLOAD_PERMIT,
  input wire logic RATE_SELECT_LSB,
  input wire logic RATE_SELECT_MSB,
  input wire logic LOOPBACK_SELECT,
  input wire logic FILL_TYPE_SELECT,
  input wire logic EXTRA_BIT_MODE,
  input wire logic WORD_STROBE_IN,
  output logic READY_FOR_PAYLOAD,
  output logic SERIAL_LINE_OUT,
  output logic LOOPBACK_LINE_OUT,
  output logic FRAME_IS_CONTROL,
  output logic FRAME_IS_FILL,
  output logic STROBE_OVERRUN
);

  // ****************************************************************
  // helpers
  // ****************************************************************
  function automatic logic [4:0] ones_in(input logic [23:0] v, input logic wide);
    logic [4:0] n;
    n = 5'h00;
    for (int i = 0; i < sltfi_pkg::FRAME_MAX; i++) begin
      if (wide || i < sltfi_pkg::NARROW_BITS + sltfi_pkg::CODING_BITS) begin
        n = n + {4'h0, v[i]};
      end
    end
    return n;
  endfunction

  // ****************************************************************
  // declarations
  // ****************************************************************
  sltfi_pkg::sltfi_ser_e state;
  sltfi_pkg::sltfi_word_s in_word;
  sltfi_pkg::sltfi_word_s head_word;
  logic strobe_prev;
  logic strobe_rise;
  logic ctrl_req;
  logic data_req;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic push;
  logic load;
  logic pop;
  logic tick;
  logic last_bit;
  logic [2:0] div_cnt;
  logic [2:0] div_last;
  logic [4:0] bit_cnt;
  logic [4:0] bit_last;
  logic [23:0] shreg;
  logic [23:0] next_frame;
  logic next_wide;
  logic next_ctrl;
  logic next_fill;
  logic [19:0] next_data;
  logic [3:0] next_code;
  logic next_flag;
  logic flag_toggle;
  logic disp_pos;
  logic [4:0] frame_ones;
  logic [4:0] frame_half;
  logic line;
  logic next_line;

  // ****************************************************************
  // strobe edge and request decode
  // ****************************************************************
  always_ff @(posedge CORE_CLK) begin
    if (!RESETN) begin
      strobe_prev <= sltfi_pkg::RST_STROBE;
    end else begin
      strobe_prev <= WORD_STROBE_IN;
    end
  end

  assign strobe_rise = WORD_STROBE_IN & ~strobe_prev;
  // an undriven request pin reads high and so never requests a frame
  assign ctrl_req = ~CONTROL_WORD_REQUEST_N;
  assign data_req = ~PAYLOAD_REQUEST_N;

  // words are taken only on the strobe edge, and only while ready was shown
  assign push = strobe_rise & LINK_PAYLOAD_PERMIT & READY_FOR_PAYLOAD & fifo_in_ready
              & (ctrl_req | data_req);

  always_comb begin
    in_word.wide = WIDE_WORD_SELECT;
    in_word.ctrl = ctrl_req;  // control wins when both are low
    in_word.flag = EXTRA_FLAG_IN;
    // narrow mode drops the top four inputs
    in_word.data = WIDE_WORD_SELECT ? PARALLEL_WORD_IN : {4'h0, PARALLEL_WORD_IN[15:0]};
  end

  // ****************************************************************
  // word buffer
  // ****************************************************************
  sltfi_fifo #(
    .WIDTH($bits(sltfi_pkg::sltfi_word_s)),
    .DEPTH(DEPTH)
  ) u_fifo (
    .clk(CORE_CLK),
    .rst_n(RESETN),
    .in_data(in_word),
    .in_valid(push),
    .in_ready(fifo_in_ready),
    .out_data(head_word),
    .out_valid(fifo_out_valid),
    .out_ready(pop)
  );

  // ready needs both the permit and buffer room, so a slow line throttles the user
  always_ff @(posedge CORE_CLK) begin
    if (!RESETN) begin
      READY_FOR_PAYLOAD <= sltfi_pkg::RST_READY;
    end else begin
      READY_FOR_PAYLOAD <= LINK_PAYLOAD_PERMIT & fifo_in_ready;
    end
  end

  // ****************************************************************
  // frame assembly
  // ****************************************************************
  // a strobe that lands mid-frame loads nothing and the buffer holds its words
  assign load = strobe_rise & (state == sltfi_pkg::SER_IDLE);
  // buffered words wait while the permit is withdrawn
  assign pop = load & fifo_out_valid & LINK_PAYLOAD_PERMIT;

  always_comb begin
    next_fill = ~pop;
    next_ctrl = pop & head_word.ctrl;
    next_wide = pop ? head_word.wide : WIDE_WORD_SELECT;
    if (pop) begin
      next_data = head_word.data;
    end else if (!FILL_TYPE_SELECT) begin
      next_data = sltfi_pkg::FILL_ZERO_WORD;
    end else begin
      // pick the one-type variant that pulls the running balance back
      next_data = disp_pos ? sltfi_pkg::FILL_ONE_WORD : ~sltfi_pkg::FILL_ONE_WORD;
    end
    if (!next_wide) begin
      next_data = {4'h0, next_data[15:0]};
    end
    next_flag = (EXTRA_BIT_MODE && pop) ? head_word.flag : flag_toggle;
    next_code = 4'h0;
    next_code[sltfi_pkg::CODE_FLAG_POS] = next_flag;
    next_code[sltfi_pkg::CODE_CTRL_POS] = next_ctrl;
    next_code[sltfi_pkg::CODE_FILL_POS] = next_fill;
    next_code[sltfi_pkg::CODE_DATA_POS] = ~(next_ctrl | next_fill);
    // coding bits sit directly above the last data bit
    next_frame = next_wide ? {next_code, next_data} : {4'h0, next_code, next_data[15:0]};
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RESETN) begin
      flag_toggle <= sltfi_pkg::RST_FLAG_TOGGLE;
    end else if (load) begin
      flag_toggle <= ~flag_toggle;
    end
  end

  // only the sign of the balance is kept; it is enough to choose the fill variant
  assign frame_ones = ones_in(next_frame, next_wide);
  assign frame_half = next_wide ? 5'h0C : 5'h0A;

  always_ff @(posedge CORE_CLK) begin
    if (!RESETN) begin
      disp_pos <= sltfi_pkg::RST_DISP_POS;
    end else if (load && frame_ones != frame_half) begin
      disp_pos <= (frame_ones > frame_half);
    end
  end

  // ****************************************************************
  // bit rate divider
  // ****************************************************************
  assign div_last = 3'((4'h1 << {RATE_SELECT_MSB, RATE_SELECT_LSB}) - 4'h1);
  assign tick = (div_cnt == div_last);

  always_ff @(posedge CORE_CLK) begin
    if (!RESETN) begin
      div_cnt <= 3'h0;
    end else if (load || tick) begin
      div_cnt <= 3'h0;
    end else begin
      div_cnt <= div_cnt + 3'h1;
    end
  end

  // ****************************************************************
  // serialiser
  // ****************************************************************
  assign last_bit = (bit_cnt == bit_last);

  always_ff @(posedge CORE_CLK) begin
    if (!RESETN) begin
      state <= sltfi_pkg::SER_IDLE;
    end else begin
      case (state)
        sltfi_pkg::SER_IDLE: begin
          if (load) begin
            state <= sltfi_pkg::SER_SHIFT;
          end
        end
        sltfi_pkg::SER_SHIFT: begin
          if (tick && last_bit) begin
            state <= sltfi_pkg::SER_IDLE;
          end
        end
        default: begin
          state <= sltfi_pkg::SER_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RESETN) begin
      shreg <= 24'h000000;
      bit_cnt <= 5'h00;
      bit_last <= sltfi_pkg::LAST_BIT_NARROW;
    end else if (load) begin
      shreg <= next_frame;
      bit_cnt <= 5'h00;
      bit_last <= next_wide ? sltfi_pkg::LAST_BIT_WIDE : sltfi_pkg::LAST_BIT_NARROW;
    end else if (state == sltfi_pkg::SER_SHIFT && tick) begin
      shreg <= {1'b0, shreg[23:1]};
      bit_cnt <= bit_cnt + 5'h01;
    end
  end

  always_comb begin
    next_line = line;
    if (load) begin
      next_line = next_frame[0];
    end else if (state == sltfi_pkg::SER_SHIFT && tick) begin
      next_line = last_bit ? sltfi_pkg::RST_LINE : shreg[1];
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RESETN) begin
      line <= sltfi_pkg::RST_LINE;
    end else begin
      line <= next_line;
    end
  end

  // both outputs are registered from next_line, so bit 0 shows one cycle after the strobe
  always_ff @(posedge CORE_CLK) begin
    if (!RESETN) begin
      SERIAL_LINE_OUT <= sltfi_pkg::RST_LINE;
      LOOPBACK_LINE_OUT <= sltfi_pkg::RST_LINE;
    end else begin
      SERIAL_LINE_OUT <= ~LOOPBACK_SELECT & next_line;
      LOOPBACK_LINE_OUT <= LOOPBACK_SELECT & next_line;
    end
  end

  // ****************************************************************
  // frame status
  // ****************************************************************
  always_ff @(posedge CORE_CLK) begin
    if (!RESETN) begin
      FRAME_IS_CONTROL <= 1'b0;
      FRAME_IS_FILL <= 1'b0;
    end else if (load) begin
      FRAME_IS_CONTROL <= next_ctrl;
      FRAME_IS_FILL <= next_fill;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RESETN) begin
      STROBE_OVERRUN <= 1'b0;
    end else begin
      STROBE_OVERRUN <= strobe_rise & (state == sltfi_pkg::SER_SHIFT);
    end
  end

endmodule // sltfi_top
`default_nettype wire

// ===== dv/sltfi_sva.sv
// Purpose: port checks for the transmit frame input
// Assumes: one clock, RESETN synchronous active low
// Notes: bound to every sltfi_top
`timescale 1ns/10ps
`default_nettype none
module sltfi_sva (
  input wire logic CORE_CLK,
  input wire logic RESETN,
  input wire logic LINK_PAYLOAD_PERMIT,
  input wire logic LOOPBACK_SELECT,
  input wire logic WORD_STROBE_IN,
  input wire logic READY_FOR_PAYLOAD,
  input wire logic SERIAL_LINE_OUT,
  input wire logic LOOPBACK_LINE_OUT,
  input wire logic FRAME_IS_CONTROL,
  input wire logic FRAME_IS_FILL,
  input wire logic STROBE_OVERRUN
);
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RESETN);
  // ****************************************************************
  // checks
  // ****************************************************************
  loop_quiet_a: assert property (LOOPBACK_SELECT && $past(LOOPBACK_SELECT)
      |-> !SERIAL_LINE_OUT)
    else $error("normal line active in loopback");
  normal_quiet_a: assert property (!LOOPBACK_SELECT && !$past(LOOPBACK_SELECT)
      |-> !LOOPBACK_LINE_OUT)
    else $error("loopback line active in normal mode");
  ready_permit_a: assert property (!LINK_PAYLOAD_PERMIT |=> !READY_FOR_PAYLOAD)
    else $error("ready without permit");
  ready_rise_a: assert property ($rose(READY_FOR_PAYLOAD)
      |-> $past(LINK_PAYLOAD_PERMIT))
    else $error("ready rose without permit");
  // room only shrinks on a strobe, so ready must hold without one
  ready_stands_a: assert property (READY_FOR_PAYLOAD && LINK_PAYLOAD_PERMIT
      && !WORD_STROBE_IN && !$past(WORD_STROBE_IN) |=> READY_FOR_PAYLOAD)
    else $error("ready dropped without cause");
  overrun_pulse_a: assert property (STROBE_OVERRUN |=> !STROBE_OVERRUN)
    else $error("overrun longer than one cycle");
  overrun_cause_a: assert property (STROBE_OVERRUN |-> $past(WORD_STROBE_IN)
      && !$past(WORD_STROBE_IN, 2))
    else $error("overrun without strobe edge");
  ctrl_load_a: assert property ($rose(FRAME_IS_CONTROL) |-> $past(WORD_STROBE_IN))
    else $error("control frame began off strobe");
  fill_load_a: assert property ($rose(FRAME_IS_FILL) |-> $past(WORD_STROBE_IN))
    else $error("fill frame began off strobe");
  cover property (STROBE_OVERRUN);
  cover property (FRAME_IS_CONTROL);
  cover property (!READY_FOR_PAYLOAD && LINK_PAYLOAD_PERMIT);
endmodule // sltfi_sva
bind sltfi_top sltfi_sva u_sva (.CORE_CLK, .RESETN, .LINK_PAYLOAD_PERMIT, .LOOPBACK_SELECT,
  .WORD_STROBE_IN, .READY_FOR_PAYLOAD, .SERIAL_LINE_OUT, .LOOPBACK_LINE_OUT,
  .FRAME_IS_CONTROL, .FRAME_IS_FILL, .STROBE_OVERRUN);
`default_nettype wire

// ===== dv/sltfi_rx_model.sv
// Purpose: far-end receiver: grants permit, samples one frame per arm
// Assumes: per is the bit period in clock cycles
// Notes: always samples 24 bits; narrow frames leave the top four unused
`timescale 1ns/10ps
`default_nettype none
module sltfi_rx_model #(
  parameter int LOCK_CYCLES = 8
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic line,
  input wire logic arm,
  input wire logic drop,
  input wire logic [3:0] per,
  output logic permit,
  output logic [23:0] frame,
  output logic busy
);
  int lock_cnt;
  always @(posedge clk) begin
    if (!rst_n) lock_cnt <= 0;
    else if (lock_cnt < LOCK_CYCLES) lock_cnt <= lock_cnt + 1;
  end
  // permit only once lock has settled after reset
  assign permit = (lock_cnt == LOCK_CYCLES) && !drop;
  initial begin
    busy = 1'b0;
    frame = 24'h0;
  end
  // each bit is sampled on the first falling edge after it starts, half a cycle in
  always @(posedge clk) begin
    if (arm && !busy) begin
      busy = 1'b1;
      @(negedge clk);
      for (int i = 0; i < 24; i++) begin
        frame[i] = line;
        repeat (per) @(negedge clk);
      end
      busy = 1'b0;
    end
  end
endmodule // sltfi_rx_model
`default_nettype wire

// ===== dv/sltfi_top_bench.sv
// Purpose: self-checking bench for the transmit frame input
// Assumes: inputs change on the falling edge
// Notes: a word pushed at one strobe leaves at a later one
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin mismatches++; \
  $display("[FAIL] t=%0t got %0h exp %0h", $time, (a), (b)); end end
module sltfi_top_bench;
  logic clk, rst_n, strobe, creq_n, dreq_n, wide, lb, ff, xmode, xflag, arm, drop;
  logic permit, ready, sout, loopback_line_out, is_ctrl, is_fill, ovr, busy, seen, c0_prev;
  logic [1:0] rate;
  logic [19:0] word;
  logic [23:0] frame;
  int mismatches, cmp_count, cyc;
  sltfi_top DUT (.CORE_CLK(clk), .RESETN(rst_n), .PARALLEL_WORD_IN(word),
    .EXTRA_FLAG_IN(xflag), .CONTROL_WORD_REQUEST_N(creq_n), .PAYLOAD_REQUEST_N(dreq_n),
    .WIDE_WORD_SELECT(wide), .LINK_PAYLOAD_PERMIT(permit), .RATE_SELECT_LSB(rate[0]),
    .RATE_SELECT_MSB(rate[1]), .LOOPBACK_SELECT(lb), .FILL_TYPE_SELECT(ff),
    .EXTRA_BIT_MODE(xmode), .WORD_STROBE_IN(strobe), .READY_FOR_PAYLOAD(ready),
    .SERIAL_LINE_OUT(sout), .LOOPBACK_LINE_OUT(loopback_line_out), .FRAME_IS_CONTROL(is_ctrl),
    .FRAME_IS_FILL(is_fill), .STROBE_OVERRUN(ovr));
  sltfi_rx_model FAR (.clk(clk), .rst_n(rst_n), .line(lb ? loopback_line_out : sout), .arm(arm),
    .drop(drop), .per(4'h1 << rate), .permit(permit), .frame(frame), .busy(busy));
  task automatic report_and_stop();
    $display("mismatches=%0d comparisons=%0d", mismatches, cmp_count);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic strobe_word(input logic c_n, input logic d_n, input logic [19:0] w);
    int n;
    n = 0;
    // one low cycle first, so back-to-back calls still give a fresh rising edge
    @(negedge clk);
    // with the permit withdrawn the strobe goes out at once to show it is refused
    while (ready !== 1'b1 && permit === 1'b1 && !(c_n && d_n) && n < 50) begin
      @(negedge clk);
      n++;
    end
    if (n == 50) begin
      mismatches++;
      report_and_stop();
    end
    strobe = 1'b1; creq_n = c_n; dreq_n = d_n; word = w; arm = !busy;
    @(negedge clk);
    strobe = 1'b0; creq_n = 1'b1; dreq_n = 1'b1; arm = 1'b0;
  endtask
  task automatic wait_idle();
    int n;
    n = 0;
    @(negedge clk);
    while (busy === 1'b1 && n < 400) begin
      @(negedge clk);
      n++;
    end
    if (n == 400) begin
      mismatches++;
      report_and_stop();
    end
  endtask
  task automatic chk_frame(input logic [19:0] w, input logic c, input logic f);
    logic [3:0] code;
    logic [19:0] d;
    code = wide ? frame[23:20] : frame[19:16];
    d = wide ? frame[19:0] : {4'h0, frame[15:0]};
    if (f && ff) `CHK(d == 20'h0007F || d == 20'h0FF80, 1'b1)
    else `CHK(d, wide ? w : {4'h0, w[15:0]})
    `CHK(code[3:1], {~(c | f), f, c})
    `CHK({is_ctrl, is_fill}, {c, f})
    if (xmode && !f) `CHK(code[0], xflag)
    else if (!xmode && seen) `CHK(code[0], ~c0_prev)
    c0_prev = xmode ? ~c0_prev : code[0];
    seen = 1'b1;
  endtask
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      report_and_stop();
    end
  end
  initial begin
    rst_n = 0; strobe = 0; creq_n = 1; dreq_n = 1; wide = 0; lb = 0; ff = 0; xmode = 0;
    xflag = 0; arm = 0; drop = 0; rate = 0; word = 0; seen = 0; c0_prev = 0;
    mismatches = 0; cmp_count = 0; cyc = 0;
    repeat (3) @(negedge clk);
    rst_n = 1;
    repeat (12) @(negedge clk);
    `CHK(ready, 1'b1)
    // ****************************************************************
    // queueing, precedence and fill
    // ****************************************************************
    strobe_word(1, 0, 20'hA5A5C); wait_idle(); chk_frame(0, 0, 1);
    strobe_word(0, 0, 20'h3C96F); wait_idle(); chk_frame(20'hA5A5C, 0, 0);
    strobe_word(1, 1, 0); wait_idle(); chk_frame(20'h3C96F, 1, 0);
    ff = 1;
    strobe_word(1, 1, 0); wait_idle(); chk_frame(0, 0, 1);
    ff = 0;
    // ****************************************************************
    // every rate, loopback, width and flag mode
    // ****************************************************************
    for (int s = 0; s < 4; s++) begin
      rate = 2'(s); lb = s[0]; wide = s[1]; xmode = s[0]; xflag = s[1];
      strobe_word(1, 0, 20'h5E3A1 ^ 20'(s)); wait_idle(); chk_frame(0, 0, 1);
      strobe_word(1, 1, 0); wait_idle(); chk_frame(20'h5E3A1 ^ 20'(s), 0, 0);
    end
    // ****************************************************************
    // permit withdrawn: requests ignored
    // ****************************************************************
    drop = 1; xmode = 0; lb = 0; rate = 0;
    repeat (2) @(negedge clk);
    `CHK(ready, 1'b0)
    strobe_word(1, 0, 20'h12345); wait_idle(); chk_frame(0, 0, 1);
    drop = 0;
    repeat (3) @(negedge clk);
    strobe_word(1, 1, 0); wait_idle(); chk_frame(0, 0, 1);
    // ****************************************************************
    // fill the FIFO during a slow frame, then drain in order
    // ****************************************************************
    rate = 2'h3; wide = 0;
    strobe_word(1, 1, 0);
    for (int i = 0; i < 16; i++) begin
      strobe_word(1, 0, 20'h0C000 + 20'(i * 273));
      `CHK(ovr, 1'b1)
    end
    @(negedge clk);
    `CHK(ready, 1'b0)
    wait_idle(); chk_frame(0, 0, 1);
    rate = 0;
    for (int i = 0; i < 16; i++) begin
      strobe_word(1, 1, 0); wait_idle(); chk_frame(20'h0C000 + 20'(i * 273), 0, 0);
    end
    report_and_stop();
  end
endmodule // sltfi_top_bench
`default_nettype wire
